// ---- sim/ildpc_line_model.sv ----
/*
  Far side of the line: master, load and analog comparators.
  Assumes the bench commands master level, wake burst and a short.
*/
`default_nettype none
module ildpc_line_model (
  input wire logic cq_source_en,
  input wire logic cq_sink_en,
  input wire logic master_level,
  input wire logic master_wake,
  input wire logic line_short,
  output logic cq_above_high,
  output logic cq_below_low,
  output logic over_limit,
  output logic wake_current
);
  logic driving;
  logic line_high;
  assign driving = cq_source_en | cq_sink_en;
  // Master outfights our driver during a wake burst
  assign line_high = master_wake ? master_level :
    cq_source_en ? 1'h1 : cq_sink_en ? 1'h0 : master_level;
  // Heavy current flows only while both ends drive
  assign wake_current = master_wake & driving;
  // A short draws current only while we drive
  assign over_limit = line_short & driving;
  // No mid-level line modelled, so the comparators never disagree
  assign cq_above_high = line_high;
  assign cq_below_low = ~line_high;
endmodule
`default_nettype wire

// ---- sim/io_link_device_phy_control_test.sv ----
/*
  Self-checking bench of the line transceiver control block.
  Assumes shortened timer parameters and the line model beside it.
*/
`default_nettype none
module io_link_device_phy_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MIN_C = 10;
  localparam int MAX_C = 20;
  localparam int PULSE_C = 30;
  localparam int BLANK_C = 15;
  localparam int RETRY_C = 100;
  localparam int SRC = 0;
  localparam int FLAG = 1;
  localparam int WAKE = 2;
  typedef struct packed {
    logic en; logic tx; logic ml; logic src; logic snk; logic rx;
  } ildpc_row_t;
  // Last enabled row leaves the line low, so the wake reference is low
  ildpc_row_t rows [6] = '{6'h11, 6'h08, 6'h24, 6'h2c, 6'h33, 6'h01};
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic en_pin = 1'h0, tx_pin = 1'h1, temp_warn = 1'h0;
  logic temp_shutdown = 1'h0, temp_release = 1'h1, supply_good = 1'h1;
  logic strap_grounded = 1'h0, strap_open = 1'h0;
  logic master_level = 1'h0, master_wake = 1'h0, line_short = 1'h0;
  logic cq_above_high, cq_below_low, over_limit, wake_current;
  logic cq_source_en, cq_sink_en, min_sink_en, rx_out;
  logic wake_n_o, wake_n_oe, problem_flag_n_o, problem_flag_n_oe;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int compares = 0;
  int c;

  always #4 pclk = ~pclk;

  ildpc_phy_ctrl #(
    .WAKE_MIN_CYC(ildpc_pkg::CNT_W'(MIN_C)),
    .WAKE_MAX_CYC(ildpc_pkg::CNT_W'(MAX_C)),
    .WAKE_PULSE_CYC(ildpc_pkg::CNT_W'(PULSE_C)),
    .BLANK_CYC(ildpc_pkg::CNT_W'(BLANK_C)),
    .RETRY_CYC(ildpc_pkg::CNT_W'(RETRY_C))
  ) u_ildpc_phy_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .en_pin(en_pin),
    .tx_pin(tx_pin), .cq_above_high(cq_above_high),
    .cq_below_low(cq_below_low), .over_limit(over_limit),
    .wake_current(wake_current), .temp_warn(temp_warn),
    .temp_shutdown(temp_shutdown), .temp_release(temp_release),
    .supply_good(supply_good), .strap_grounded(strap_grounded),
    .strap_open(strap_open), .cq_source_en(cq_source_en),
    .cq_sink_en(cq_sink_en), .min_sink_en(min_sink_en), .rx_out(rx_out),
    .wake_n_o(wake_n_o), .wake_n_oe(wake_n_oe),
    .problem_flag_n_o(problem_flag_n_o),
    .problem_flag_n_oe(problem_flag_n_oe));

  ildpc_line_model u_ildpc_line_model (.cq_source_en(cq_source_en),
    .cq_sink_en(cq_sink_en), .master_level(master_level),
    .master_wake(master_wake), .line_short(line_short),
    .cq_above_high(cq_above_high), .cq_below_low(cq_below_low),
    .over_limit(over_limit), .wake_current(wake_current));

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Master holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic sig(input int k);
    case (k)
      SRC: return cq_source_en;
      FLAG: return problem_flag_n_oe;
      default: return wake_n_oe;
    endcase
  endfunction

  task automatic wait_val(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic count_high(input int k, input int cyc);
    c = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (sig(k) === 1'h1) c++;
    end
  endtask

  // Strap is only captured after a reset, so each mode needs one
  task automatic do_reset(input logic g, input logic o);
    @(posedge pclk);
    presetn <= 1'h0;
    strap_grounded <= g;
    strap_open <= o;
    repeat (12) @(posedge pclk);
    check("rx_out", rx_out, 1);
    check("src_rst", cq_source_en, 0);
    check("flag_rst", problem_flag_n_oe, 0);
    check("wake_rst", wake_n_oe, 0);
    presetn <= 1'h1;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test;
  end

  initial begin
    do_reset(1'h0, 1'h0);
    apb(1'h0, 8'h00, 32'h0);
    check("status", rd & 32'hdf, 32'h80);
    apb(1'h0, 8'h04, 32'h0);
    check("control", rd, 32'h2);
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h0, 8'h04, 32'h0);
    check("control_w", rd, 32'h0);
    apb(1'h1, 8'h04, 32'h2);
    apb(1'h0, 8'h0c, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      en_pin <= rows[i].en;
      tx_pin <= rows[i].tx;
      master_level <= rows[i].ml;
      repeat (8) @(posedge pclk);
      check("src", cq_source_en, rows[i].src);
      check("snk", cq_sink_en, rows[i].snk);
      check("rx", rx_out, rows[i].rx);
      check("flag", problem_flag_n_oe, 0);
    end
    master_level <= 1'h1;
    repeat (15) @(posedge pclk);
    master_level <= 1'h0;
    count_high(WAKE, 50);
    check("wake_width", c, PULSE_C);
    check("wake_o", wake_n_o, 0);
    // Controller stays in receive mode after the wake
    master_level <= 1'h1;
    repeat (5) @(posedge pclk);
    master_level <= 1'h0;
    count_high(WAKE, 40);
    check("wake_short", c, 0);
    master_level <= 1'h1;
    count_high(WAKE, 40);
    check("wake_long", c, 0);
    master_level <= 1'h0;
    count_high(WAKE, 40);
    check("wake_back", c, 0);
    apb(1'h0, 8'h08, 32'h0);
    check("wakes", rd, 32'h1);
    en_pin <= 1'h1;
    repeat (8) @(posedge pclk);
    master_level <= 1'h1;
    master_wake <= 1'h1;
    repeat (15) @(posedge pclk);
    master_wake <= 1'h0;
    master_level <= 1'h0;
    count_high(WAKE, 50);
    check("wake_cur", c != 0, 1);
    master_wake <= 1'h1;
    master_level <= 1'h1;
    repeat (25) @(posedge pclk);
    master_wake <= 1'h0;
    master_level <= 1'h0;
    count_high(WAKE, 50);
    check("wake_cur_long", c, 0);
    tx_pin <= 1'h0;
    line_short <= 1'h1;
    wait_val(FLAG, 1, BLANK_C + 6);
    check("oc_flag", problem_flag_n_oe, 1);
    check("oc_flag_o", problem_flag_n_o, 0);
    check("oc_off", cq_source_en, 0);
    wait_val(SRC, 1, RETRY_C + 20);
    count_high(SRC, BLANK_C + 10);
    // First high cycle was spent by the wait above
    check("retry_on", c + 1, BLANK_C);
    line_short <= 1'h0;
    wait_val(SRC, 1, RETRY_C + 20);
    repeat (BLANK_C + 10) @(posedge pclk);
    check("recovered", cq_source_en, 1);
    check("flag_kept", problem_flag_n_oe, 1);
    en_pin <= 1'h0;
    repeat (6) @(posedge pclk);
    check("flag_en_low", problem_flag_n_oe, 0);
    en_pin <= 1'h1;
    repeat (6) @(posedge pclk);
    check("flag_cleared", problem_flag_n_oe, 0);
    temp_warn <= 1'h1;
    repeat (6) @(posedge pclk);
    check("warn", problem_flag_n_oe, 1);
    temp_warn <= 1'h0;
    temp_shutdown <= 1'h1;
    temp_release <= 1'h0;
    repeat (6) @(posedge pclk);
    check("warn_gone", problem_flag_n_oe, 0);
    check("shdn", cq_source_en, 0);
    temp_shutdown <= 1'h0;
    temp_release <= 1'h1;
    repeat (6) @(posedge pclk);
    check("shdn_end", cq_source_en, 1);
    en_pin <= 1'h0;
    supply_good <= 1'h0;
    repeat (6) @(posedge pclk);
    check("uv_flag", problem_flag_n_oe, 1);
    supply_good <= 1'h1;
    repeat (6) @(posedge pclk);
    check("uv_gone", problem_flag_n_oe, 0);
    do_reset(1'h0, 1'h1);
    apb(1'h0, 8'h00, 32'h0);
    check("mode_open", rd[1:0], 1);
    en_pin <= 1'h1;
    line_short <= 1'h1;
    wait_val(FLAG, 1, BLANK_C + 14);
    check("open_flag", problem_flag_n_oe, 1);
    check("open_on", cq_source_en, 1);
    line_short <= 1'h0;
    do_reset(1'h1, 1'h0);
    check("min_sink", min_sink_en, 1);
    apb(1'h0, 8'h00, 32'h0);
    check("mode_gnd", rd[1:0], 2);
    en_pin <= 1'h1;
    line_short <= 1'h1;
    repeat (BLANK_C + 20) @(posedge pclk);
    check("gnd_flag", problem_flag_n_oe, 0);
    check("gnd_on", cq_source_en, 1);
    finish_test;
  end
endmodule
`default_nettype wire

// ---- src/ildpc_phy_ctrl.sv ----
/*
  Control logic of a device-side single-wire line transceiver:
  driver decode, receive level, wake detection, current fault
  handling, thermal handling, fault flag and an APB register file.
  Assumes analog comparators deliver the line, current, temperature
  and strap levels as asynchronous digital inputs; pin pulls turn an
  open enable into low and an open transmit pin into high.
*/
// Implementation choices: the register addresses and the APB interface to the registers.
// How it works
// - A master-driven level reversal is reported on the wake pin.
// - Overcurrent too short or too long keeps the wake pin released.
// - Driver off: level change inside the window pulses wake low.
// - Driver on: heavy line current inside the window pulses wake low.
// - Resistor strap: variable limit, flag, shut-off and retry all active.
// - Open strap: flag only, no shut-off and no retry.
// - Grounded strap: master mode, small sink on, no flag or shut-off.
// - Overcurrent past blanking pulls the flag low, except with grounded strap; only the resistor strap also stops the driver.
// - With recovery on, retry for one blanking time each retry interval.
// - Toggling enable clears the current fault indication.
// - Above warning temperature the flag is held low.
// - Above shutdown temperature the driver stops until cooled past hysteresis.
// - Flag low on current fault, thermal warning or undervoltage.
// - Enable low gives high impedance; enable high drives inverse of transmit.
// - Receive output is the inverted line level with hysteresis.
// - Enable low keeps the current indicator inactive.
// - Wake pulse in driver-off mode lasts about 225us.
// - Overcurrent blanking lasts at least 175us, typically 200us.
// - Retry interval is typically 15ms.
// - Flag asserts within 280us of a current fault starting.
`default_nettype none
module ildpc_phy_ctrl #(
  parameter logic [ildpc_pkg::CNT_W-1:0] WAKE_MIN_CYC =
    ildpc_pkg::CNT_W'(ildpc_pkg::WAKE_MIN_CYC),
  parameter logic [ildpc_pkg::CNT_W-1:0] WAKE_MAX_CYC =
    ildpc_pkg::CNT_W'(ildpc_pkg::WAKE_MAX_CYC),
  parameter logic [ildpc_pkg::CNT_W-1:0] WAKE_PULSE_CYC =
    ildpc_pkg::CNT_W'(ildpc_pkg::WAKE_PULSE_CYC),
  parameter logic [ildpc_pkg::CNT_W-1:0] BLANK_CYC =
    ildpc_pkg::CNT_W'(ildpc_pkg::BLANK_CYC),
  parameter logic [ildpc_pkg::CNT_W-1:0] RETRY_CYC =
    ildpc_pkg::CNT_W'(ildpc_pkg::RETRY_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic en_pin,
  input wire logic tx_pin,
  input wire logic cq_above_high,
  input wire logic cq_below_low,
  input wire logic over_limit,
  input wire logic wake_current,
  input wire logic temp_warn,
  input wire logic temp_shutdown,
  input wire logic temp_release,
  input wire logic supply_good,
  input wire logic strap_grounded,
  input wire logic strap_open,
  output logic cq_source_en,
  output logic cq_sink_en,
  output logic min_sink_en,
  output logic rx_out,
  output logic wake_n_o,
  output logic wake_n_oe,
  output logic problem_flag_n_o,
  output logic problem_flag_n_oe
);
  logic [ildpc_pkg::SYNC_W-1:0] pins_s;
  logic en_s, tx_s, above_s, below_s, over_s, wcur_s;
  logic warn_s, shdn_in_s, release_s, supply_s, gnd_s, open_s;
  logic [1:0] boot_ff;
  logic strap_done_ff;
  ildpc_pkg::ildpc_strap_t strap_ff;
  logic en_d_ff, en_edge, clr_ff, fault_set;
  ildpc_pkg::ildpc_oc_t oc_st_ff;
  logic [ildpc_pkg::CNT_W-1:0] oc_cnt_ff, wake_cnt_ff;
  logic cur_fault_ff, shdn_ff, rx_ff, drive_ok, driving;
  logic src_ff, snk_ff, flag_ff, base_ff, wake_act_ff;
  logic lvl_hit, lvl_exp, cur_hit, wake_hit, wake_en_ff;
  logic [15:0] wakes_ff;
  logic [31:0] prdata_ff, rd_data;
  logic rd_hit;

  ildpc_sync #(.W(ildpc_pkg::SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({en_pin, tx_pin, cq_above_high, cq_below_low, over_limit,
          wake_current, temp_warn, temp_shutdown, temp_release,
          supply_good, strap_grounded, strap_open}),
    .dout(pins_s)
  );
  assign {en_s, tx_s, above_s, below_s, over_s, wcur_s, warn_s,
          shdn_in_s, release_s, supply_s, gnd_s, open_s} = pins_s;

  // Strap is caught once the synchroniser has filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_ff <= '0;
      strap_done_ff <= 1'b0;
      strap_ff <= ildpc_pkg::ILDPC_STRAP_OPEN;
    end else if (!strap_done_ff) begin
      boot_ff <= boot_ff + 1'b1;
      if (boot_ff == 2'(ildpc_pkg::BOOT_CYC)) begin
        strap_done_ff <= 1'b1;
        strap_ff <= gnd_s ? ildpc_pkg::ILDPC_STRAP_GND :
                    open_s ? ildpc_pkg::ILDPC_STRAP_OPEN :
                    ildpc_pkg::ILDPC_STRAP_RES;
      end
    end
  end
  assign min_sink_en = strap_ff == ildpc_pkg::ILDPC_STRAP_GND;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_d_ff <= 1'b0;
    end else begin
      en_d_ff <= en_s;
    end
  end
  assign en_edge = en_s ^ en_d_ff;

  // Thermal latch with hysteresis; release only once cooled enough
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shdn_ff <= 1'b0;
    end else if (shdn_in_s) begin
      shdn_ff <= 1'b1;
    end else if (release_s) begin
      shdn_ff <= 1'b0;
    end
  end

  assign drive_ok = en_s && strap_done_ff && !shdn_ff && supply_s;
  assign driving = drive_ok && oc_st_ff != ildpc_pkg::OC_OFF;

  // Current fault sequencer, all timing from pclk counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_st_ff <= ildpc_pkg::OC_NORMAL;
      oc_cnt_ff <= '0;
    end else if (!en_s || en_edge) begin
      oc_st_ff <= ildpc_pkg::OC_NORMAL;
      oc_cnt_ff <= '0;
    end else begin
      oc_cnt_ff <= oc_cnt_ff + 1'b1;
      case (oc_st_ff)
        ildpc_pkg::OC_NORMAL: begin
          oc_cnt_ff <= '0;
          if (driving && over_s) begin
            oc_st_ff <= ildpc_pkg::OC_BLANK;
          end
        end
        ildpc_pkg::OC_BLANK: begin
          if (!over_s || !driving) begin
            oc_st_ff <= ildpc_pkg::OC_NORMAL;
          end else if (oc_cnt_ff == BLANK_CYC - 1'b1) begin
            oc_cnt_ff <= '0;
            // Only the resistor strap stops the driver
            oc_st_ff <= strap_ff == ildpc_pkg::ILDPC_STRAP_RES ?
                        ildpc_pkg::OC_OFF : ildpc_pkg::OC_NORMAL;
          end
        end
        ildpc_pkg::OC_OFF: begin
          if (oc_cnt_ff == RETRY_CYC - 1'b1) begin
            oc_cnt_ff <= '0;
            oc_st_ff <= ildpc_pkg::OC_RETRY;
          end
        end
        ildpc_pkg::OC_RETRY: begin
          if (oc_cnt_ff == BLANK_CYC - 1'b1) begin
            oc_cnt_ff <= '0;
            oc_st_ff <= over_s ? ildpc_pkg::OC_OFF :
                        ildpc_pkg::OC_NORMAL;
          end
        end
        default: begin
          oc_st_ff <= ildpc_pkg::OC_NORMAL;
        end
      endcase
    end
  end

  // Grounded strap never raises the current fault
  assign fault_set = over_s && driving &&
    strap_ff != ildpc_pkg::ILDPC_STRAP_GND && oc_cnt_ff == BLANK_CYC - 1'b1 &&
    (oc_st_ff == ildpc_pkg::OC_BLANK || oc_st_ff == ildpc_pkg::OC_RETRY);

  // A new fault wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_fault_ff <= 1'b0;
    end else if (fault_set) begin
      cur_fault_ff <= 1'b1;
    end else if (en_edge || clr_ff) begin
      cur_fault_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ff <= 1'b0;
      snk_ff <= 1'b0;
    end else begin
      src_ff <= driving && !tx_s;
      snk_ff <= driving && tx_s;
    end
  end
  assign cq_source_en = src_ff;
  assign cq_sink_en = snk_ff;

  // Between thresholds the last clean level is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ff <= 1'b1;
    end else if (above_s) begin
      rx_ff <= 1'b0;
    end else if (below_s) begin
      rx_ff <= 1'b1;
    end
  end
  assign rx_out = rx_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= (cur_fault_ff && en_s &&
                  strap_ff != ildpc_pkg::ILDPC_STRAP_GND) ||
                 warn_s || !supply_s;
    end
  end
  assign problem_flag_n_o = 1'b0;
  assign problem_flag_n_oe = flag_ff;

  // Reference level follows the line except while a reversal is timed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_ff <= 1'b1;
    end else if (en_s || lvl_exp) begin
      base_ff <= rx_ff;
    end
  end

  ildpc_wake_det #(.MIN_CYC(WAKE_MIN_CYC), .MAX_CYC(WAKE_MAX_CYC)) u_lvl (
    .pclk(pclk),
    .presetn(presetn),
    .active(!en_s && rx_ff != base_ff),
    .hit(lvl_hit),
    .expired(lvl_exp)
  );

  ildpc_wake_det #(.MIN_CYC(WAKE_MIN_CYC), .MAX_CYC(WAKE_MAX_CYC)) u_cur (
    .pclk(pclk),
    .presetn(presetn),
    .active(en_s && wcur_s),
    .hit(cur_hit),
    .expired()
  );
  assign wake_hit = lvl_hit || cur_hit;

  // Back-to-back wakes do not stretch a running pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_cnt_ff <= '0;
      wake_act_ff <= 1'b0;
    end else if (wake_act_ff) begin
      wake_cnt_ff <= wake_cnt_ff - 1'b1;
      wake_act_ff <= wake_cnt_ff != 1'b1;
    end else if (wake_hit && wake_en_ff) begin
      // Loaded full so the pin stays low for exactly the pulse count
      wake_cnt_ff <= WAKE_PULSE_CYC;
      wake_act_ff <= 1'b1;
    end
  end
  assign wake_n_o = 1'b0;
  assign wake_n_oe = wake_act_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakes_ff <= '0;
    end else if (wake_hit && wake_en_ff && !wake_act_ff) begin
      wakes_ff <= wakes_ff + 1'b1;
    end
  end

  // APB: zero wait states, error only on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en_ff <= ildpc_pkg::CTL_WAKE_EN_RST;
      clr_ff <= 1'b0;
    end else begin
      clr_ff <= 1'b0;
      if (psel && penable && pwrite &&
          paddr == ildpc_pkg::ADDR_CONTROL) begin
        wake_en_ff <= pwdata[ildpc_pkg::CTL_WAKE_EN];
        clr_ff <= pwdata[ildpc_pkg::CTL_CLEAR];
      end
    end
  end

  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case (paddr)
      ildpc_pkg::ADDR_STATUS: begin
        rd_data[ildpc_pkg::ST_MODE +: 2] = strap_ff;
        rd_data[ildpc_pkg::ST_CUR_FAULT] = cur_fault_ff;
        rd_data[ildpc_pkg::ST_WARN] = warn_s;
        rd_data[ildpc_pkg::ST_SHDN] = shdn_ff;
        rd_data[ildpc_pkg::ST_DRV_OFF] = !driving;
        rd_data[ildpc_pkg::ST_WAKE] = wake_act_ff;
        rd_data[ildpc_pkg::ST_SUPPLY] = supply_s;
      end
      ildpc_pkg::ADDR_CONTROL: begin
        rd_data[ildpc_pkg::CTL_WAKE_EN] = wake_en_ff;
      end
      ildpc_pkg::ADDR_WAKES: begin
        rd_data[15:0] = wakes_ff;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (psel && !penable) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [ildpc_pkg::CNT_W-1:0] wake_hi_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_hi_cnt <= '0;
    end else begin
      wake_hi_cnt <= wake_n_oe ? wake_hi_cnt + 1'b1 : '0;
    end
  end

  sequence s_trip;
    oc_st_ff == ildpc_pkg::OC_BLANK && oc_cnt_ff == BLANK_CYC - 1'b1 &&
    over_s && driving && en_s && !en_edge &&
    strap_ff == ildpc_pkg::ILDPC_STRAP_RES;
  endsequence
  sequence s_driver_quiet;
    !cq_source_en && !cq_sink_en;
  endsequence

  chk_drive_decode: assert property (!en_s |=> s_driver_quiet)
    else $error("driver active with enable low");
  chk_no_cross: assert property (!(cq_source_en && cq_sink_en))
    else $error("source and sink both on");
  chk_rx_invert: assert property (above_s |=> !rx_out)
    else $error("receive not inverted");
  chk_wake_width: assert property ($fell(wake_n_oe) |->
    wake_hi_cnt == WAKE_PULSE_CYC)
    else $error("wake pulse width wrong");
  chk_trip_off: assert property (s_trip |=>
    oc_st_ff == ildpc_pkg::OC_OFF ##1 s_driver_quiet)
    else $error("no shut-off after blanking");
  chk_retry_start: assert property (oc_st_ff == ildpc_pkg::OC_OFF &&
    oc_cnt_ff == RETRY_CYC - 1'b1 && en_s && !en_edge |=>
    oc_st_ff == ildpc_pkg::OC_RETRY)
    else $error("retry not started");
  chk_shdn_quiet: assert property (shdn_ff |=> s_driver_quiet)
    else $error("driver on in shutdown");
  chk_flag_fault: assert property (cur_fault_ff && en_s &&
    strap_ff != ildpc_pkg::ILDPC_STRAP_GND |=> problem_flag_n_oe)
    else $error("flag missing on current fault");
  chk_flag_master: assert property (strap_ff == ildpc_pkg::ILDPC_STRAP_GND &&
    !warn_s && supply_s |=> !problem_flag_n_oe)
    else $error("flag raised in master mode");
  chk_toggle_clear: assert property (en_edge && !fault_set |=>
    !cur_fault_ff)
    else $error("enable toggle did not clear fault");
  chk_wake_start: assert property (wake_hit && wake_en_ff && !wake_act_ff
    |=> wake_n_oe [*2])
    else $error("wake pulse not started");
endmodule
`default_nettype wire

// ---- src/ildpc_pkg.sv ----
/*
  Shared constants of the line transceiver control block.
  Assumes a 125 MHz pclk and an APB master with 32-bit data.
*/
`default_nettype none
package ildpc_pkg;
  localparam int CLK_NS = 8;
  localparam int WAKE_MIN_NS = 60000;
  localparam int WAKE_MAX_NS = 100000;
  localparam int WAKE_PULSE_NS = 225000;
  localparam int BLANK_NS = 200000;
  localparam int RETRY_NS = 15000000;
  // Least times round up, longest times round down
  localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_MAX_CYC = WAKE_MAX_NS / CLK_NS;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_CYC = (RETRY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 21;
  localparam int SYNC_W = 12;
  localparam int BOOT_CYC = 3;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_WAKES = 8'h08;
  localparam int CTL_CLEAR = 0;
  localparam int CTL_WAKE_EN = 1;
  localparam logic CTL_WAKE_EN_RST = 1'b1;
  localparam int ST_MODE = 0;
  localparam int ST_CUR_FAULT = 2;
  localparam int ST_WARN = 3;
  localparam int ST_SHDN = 4;
  localparam int ST_DRV_OFF = 5;
  localparam int ST_WAKE = 6;
  localparam int ST_SUPPLY = 7;
  typedef enum logic [1:0] {
    ILDPC_STRAP_RES,
    ILDPC_STRAP_OPEN,
    ILDPC_STRAP_GND
  } ildpc_strap_t;
  typedef enum logic [1:0] {
    OC_NORMAL,
    OC_BLANK,
    OC_OFF,
    OC_RETRY
  } ildpc_oc_t;
endpackage
`default_nettype wire

// ---- src/ildpc_sync.sv ----
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes each bit is a slow level; no bus coherence is given.
*/
`default_nettype none
module ildpc_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= din[i];
          sync_ff <= meta_ff;
        end
      end
      assign dout[i] = sync_ff;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- src/ildpc_wake_det.sv ----
/*
  Measures how long a condition stands and flags a wake when it
  ends inside the open window (MIN_CYC, MAX_CYC).
  Assumes active is already synchronous to pclk.
*/
`default_nettype none
module ildpc_wake_det #(
  parameter logic [ildpc_pkg::CNT_W-1:0] MIN_CYC = '0,
  parameter logic [ildpc_pkg::CNT_W-1:0] MAX_CYC = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  output logic hit,
  output logic expired
);
  logic [ildpc_pkg::CNT_W-1:0] cnt_ff;
  logic hit_ff;

  // Saturates at the upper bound so overlong events never qualify
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (!active) begin
      cnt_ff <= '0;
    end else if (cnt_ff != MAX_CYC) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= !active && cnt_ff > MIN_CYC && cnt_ff < MAX_CYC;
    end
  end

  assign hit = hit_ff;
  assign expired = active && cnt_ff == MAX_CYC - 1'b1;
endmodule
`default_nettype wire
